// *** eph_host.v ***
// Host controller driving the strobes, address and data of a parallel nonvolatile memory
`timescale 1ns/1ps
`include "eph_consts.vh"

// Operation
// - Write needs select, strobe low, output high
// - Low address bits pick byte, any order
// - Host starts next load within window
// - Host holds strobe high one window
module eph_host
#(
    parameter [19:0] TWC_CYC   = `EPH_TWC_CYC,
    parameter [19:0] LOCK_CYC  = `EPH_LOCK_CYC
)
(
    input  wire                   clk_sys,
    input  wire                   reset,
    input  wire                   clk_en,
    input  wire                   cmd_valid,
    input  wire                   cmd_write,
    input  wire [`EPH_ADDR_W-1:0] cmd_addr,
    input  wire [`EPH_DATA_W-1:0] cmd_data,
    output reg                    cmd_ack_ff,
    output reg  [`EPH_DATA_W-1:0] rd_data_ff,
    output reg                    rd_valid_ff,
    output reg                    wr_done_ff,
    output reg                    wr_timeout_ff,
    output reg                    busy_ff,
    output reg                    mem_ce_n_ff,
    output reg                    mem_we_n_ff,
    output reg                    mem_oe_n_ff,
    output reg  [`EPH_ADDR_W-1:0] addr_lines_ff,
    output reg  [`EPH_DATA_W-1:0] data_lines_out_ff,
    output reg                    data_lines_oe_n_ff,
    input  wire [`EPH_DATA_W-1:0] data_lines_in
);
    localparam [8:0] S_LOCK  = 9'h001;
    localparam [8:0] S_IDLE  = 9'h002;
    localparam [8:0] S_RD    = 9'h004;
    localparam [8:0] S_WSET  = 9'h008;
    localparam [8:0] S_WLOW  = 9'h010;
    localparam [8:0] S_WHOLD = 9'h020;
    localparam [8:0] S_GAP   = 9'h040;
    localparam [8:0] S_POLL  = 9'h080;
    localparam [8:0] S_PGAP  = 9'h100;

    localparam [`EPH_CNT_W-1:0] STRB_LAST = `EPH_STRB_CYC - 1;
    localparam [`EPH_CNT_W-1:0] TAH_LAST  = `EPH_TAH_CYC - 1;
    localparam [`EPH_CNT_W-1:0] TACC_LAST = `EPH_TACC_CYC - 1;
    localparam [`EPH_CNT_W-1:0] LDW_END   = `EPH_LDW_CYC;
    localparam [`EPH_CNT_W-1:0] LDW_OPEN  = `EPH_LDW_OPEN_CYC;
    localparam [`EPH_CNT_W-1:0] CNT_ONE   = 1;
    localparam [`EPH_NB_W-1:0]  NB_FULL   = `EPH_PAGE_BYTES;
    localparam [`EPH_NB_W-1:0]  NB_ONE    = 1;

    reg  [8:0]              state_ff;
    reg  [8:0]              nxt_state;
    reg  [`EPH_CNT_W-1:0]   cnt_ff;
    reg  [`EPH_CNT_W-1:0]   nxt_cnt;
    reg  [`EPH_PAGE_W-1:0]  page_ff;
    reg  [`EPH_PAGE_W-1:0]  nxt_page;
    reg  [`EPH_NB_W-1:0]    nbytes_ff;
    reg  [`EPH_NB_W-1:0]    nxt_nbytes;
    reg                     have_prev_ff;
    reg                     nxt_have_prev;
    reg                     prev_tog_ff;
    reg                     nxt_prev_tog;
    reg                     nxt_cmd_ack;
    reg  [`EPH_DATA_W-1:0]  nxt_rd_data;
    reg                     nxt_rd_valid;
    reg                     nxt_wr_done;
    reg                     nxt_wr_timeout;
    reg                     nxt_ce_n;
    reg                     nxt_we_n;
    reg                     nxt_oe_n;
    reg  [`EPH_ADDR_W-1:0]  nxt_addr;
    reg  [`EPH_DATA_W-1:0]  nxt_dout;
    reg                     nxt_dq_oe_n;
    reg                     twc_start;
    wire                    lock_done;
    wire                    twc_done;
    wire                    same_page;
    wire                    tog_now;

    assign same_page = (cmd_addr[`EPH_ADDR_W-1:`EPH_PAGE_LSB] == page_ff);
    assign tog_now   = data_lines_in[`EPH_TOGGLE_BIT];

    // Runs from reset; no write strobe until it expires
    eph_timer #(.LOAD(LOCK_CYC), .RUN_AT_RESET(1)) u_lock_timer
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .start   (1'b0),
        .done_ff (lock_done)
    );

    // Bounds the completion poll in case the status bit never settles
    eph_timer #(.LOAD(TWC_CYC), .RUN_AT_RESET(0)) u_twc_timer
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .start   (twc_start),
        .done_ff (twc_done)
    );

    always @*
    begin
        nxt_state      = state_ff;
        nxt_cnt        = cnt_ff + CNT_ONE;
        nxt_page       = page_ff;
        nxt_nbytes     = nbytes_ff;
        nxt_have_prev  = have_prev_ff;
        nxt_prev_tog   = prev_tog_ff;
        nxt_cmd_ack    = 1'b0;
        nxt_rd_data    = rd_data_ff;
        nxt_rd_valid   = 1'b0;
        nxt_wr_done    = 1'b0;
        nxt_wr_timeout = wr_timeout_ff;
        nxt_ce_n       = mem_ce_n_ff;
        nxt_we_n       = mem_we_n_ff;
        nxt_oe_n       = mem_oe_n_ff;
        nxt_addr       = addr_lines_ff;
        nxt_dout       = data_lines_out_ff;
        nxt_dq_oe_n    = data_lines_oe_n_ff;
        twc_start      = 1'b0;
        case (state_ff)
            S_LOCK:
            begin
                if (lock_done)
                    nxt_state = S_IDLE;
            end
            S_IDLE:
            begin
                nxt_cnt = {`EPH_CNT_W{1'b0}};
                if (cmd_valid && !cmd_ack_ff)
                begin
                    nxt_cmd_ack = 1'b1;
                    nxt_addr    = cmd_addr;
                    nxt_ce_n    = 1'b0;
                    if (cmd_write)
                    begin
                        nxt_page    = cmd_addr[`EPH_ADDR_W-1:`EPH_PAGE_LSB];
                        nxt_nbytes  = NB_ONE;
                        nxt_dout    = cmd_data;
                        nxt_dq_oe_n = 1'b0;
                        nxt_oe_n    = 1'b1;
                        nxt_state   = S_WSET;
                    end
                    else
                    begin
                        nxt_dq_oe_n = 1'b1;
                        nxt_oe_n    = 1'b0;
                        nxt_state   = S_RD;
                    end
                end
            end
            S_RD, S_POLL:
            begin
                if (cnt_ff == TACC_LAST)
                begin
                    nxt_ce_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_cnt  = {`EPH_CNT_W{1'b0}};
                    if (state_ff == S_RD)
                    begin
                        nxt_rd_data  = data_lines_in;
                        nxt_rd_valid = 1'b1;
                        nxt_state    = S_IDLE;
                    end
                    else if ((have_prev_ff && (tog_now == prev_tog_ff)) || twc_done)
                    begin
                        // Bit 7 polling is not used: it needs the last data, toggling does not
                        nxt_wr_done    = 1'b1;
                        nxt_wr_timeout = twc_done && !(have_prev_ff && (tog_now == prev_tog_ff));
                        nxt_state      = S_IDLE;
                    end
                    else
                    begin
                        nxt_have_prev = 1'b1;
                        nxt_prev_tog  = tog_now;
                        nxt_state     = S_PGAP;
                    end
                end
            end
            S_PGAP:
            begin
                // Output enable must rise between reads for the bit to toggle
                nxt_ce_n  = 1'b0;
                nxt_oe_n  = 1'b0;
                nxt_cnt   = {`EPH_CNT_W{1'b0}};
                nxt_state = S_POLL;
            end
            S_WSET:
            begin
                // Address settled before the falling strobe
                nxt_we_n  = 1'b0;
                nxt_cnt   = {`EPH_CNT_W{1'b0}};
                nxt_state = S_WLOW;
            end
            S_WLOW:
            begin
                if (cnt_ff == STRB_LAST)
                begin
                    nxt_we_n  = 1'b1;
                    nxt_cnt   = {`EPH_CNT_W{1'b0}};
                    nxt_state = S_WHOLD;
                end
            end
            S_WHOLD:
            begin
                // Counter keeps running: the load window starts at the rising strobe
                if (cnt_ff == TAH_LAST)
                begin
                    nxt_ce_n    = 1'b1;
                    nxt_dq_oe_n = 1'b1;
                    nxt_state   = S_GAP;
                end
            end
            S_GAP:
            begin
                // Only half the window is used for new loads, leaving margin for slow timers
                if (cmd_valid && !cmd_ack_ff && cmd_write && same_page
                    && (nbytes_ff != NB_FULL) && (cnt_ff < LDW_OPEN))
                begin
                    nxt_cmd_ack = 1'b1;
                    nxt_addr    = cmd_addr;
                    nxt_dout    = cmd_data;
                    nxt_nbytes  = nbytes_ff + NB_ONE;
                    nxt_ce_n    = 1'b0;
                    nxt_dq_oe_n = 1'b0;
                    nxt_state   = S_WSET;
                end
                else if (cnt_ff >= LDW_END)
                begin
                    twc_start     = 1'b1;
                    nxt_have_prev = 1'b0;
                    nxt_cnt       = {`EPH_CNT_W{1'b0}};
                    nxt_ce_n      = 1'b0;
                    nxt_oe_n      = 1'b0;
                    nxt_state     = S_POLL;
                end
            end
            default:
            begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_ff           <= S_LOCK;
            cnt_ff             <= {`EPH_CNT_W{1'b0}};
            page_ff            <= {`EPH_PAGE_W{1'b0}};
            nbytes_ff          <= {`EPH_NB_W{1'b0}};
            have_prev_ff       <= 1'b0;
            prev_tog_ff        <= 1'b0;
            cmd_ack_ff         <= 1'b0;
            rd_data_ff         <= {`EPH_DATA_W{1'b0}};
            rd_valid_ff        <= 1'b0;
            wr_done_ff         <= 1'b0;
            wr_timeout_ff      <= 1'b0;
            busy_ff            <= 1'b1;
            mem_ce_n_ff        <= 1'b1;
            mem_we_n_ff        <= 1'b1;
            mem_oe_n_ff        <= 1'b1;
            addr_lines_ff      <= {`EPH_ADDR_W{1'b0}};
            data_lines_out_ff  <= {`EPH_DATA_W{1'b0}};
            data_lines_oe_n_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            state_ff           <= nxt_state;
            cnt_ff             <= nxt_cnt;
            page_ff            <= nxt_page;
            nbytes_ff          <= nxt_nbytes;
            have_prev_ff       <= nxt_have_prev;
            prev_tog_ff        <= nxt_prev_tog;
            cmd_ack_ff         <= nxt_cmd_ack;
            rd_data_ff         <= nxt_rd_data;
            rd_valid_ff        <= nxt_rd_valid;
            wr_done_ff         <= nxt_wr_done;
            wr_timeout_ff      <= nxt_wr_timeout;
            busy_ff            <= (nxt_state != S_IDLE);
            mem_ce_n_ff        <= nxt_ce_n;
            mem_we_n_ff        <= nxt_we_n;
            mem_oe_n_ff        <= nxt_oe_n;
            addr_lines_ff      <= nxt_addr;
            data_lines_out_ff  <= nxt_dout;
            data_lines_oe_n_ff <= nxt_dq_oe_n;
        end
    end
endmodule // eph_host

// *** eph_consts.vh ***
// Constants for the parallel nonvolatile memory host controller
`ifndef EPH_CONSTS_VH
`define EPH_CONSTS_VH

`define EPH_CLK_MHZ        40
`define EPH_ADDR_W         13
`define EPH_DATA_W         8
`define EPH_PAGE_LSB       5
`define EPH_PAGE_W         8
`define EPH_PAGE_BYTES     32
`define EPH_NB_W           6
`define EPH_TOGGLE_BIT     6

`define EPH_STRB_NS        150
`define EPH_STRB_CYC       ((`EPH_STRB_NS * `EPH_CLK_MHZ + 999) / 1000)
`define EPH_TAH_NS         100
`define EPH_TAH_CYC        ((`EPH_TAH_NS * `EPH_CLK_MHZ + 999) / 1000)
`define EPH_TACC_NS        250
`define EPH_TACC_CYC       ((`EPH_TACC_NS * `EPH_CLK_MHZ + 999) / 1000)
`define EPH_LDW_US         100
`define EPH_LDW_CYC        (`EPH_LDW_US * `EPH_CLK_MHZ)
`define EPH_LDW_OPEN_CYC   (`EPH_LDW_CYC / 2)
`define EPH_TWC_MS         5
`define EPH_TWC_CYC        (`EPH_TWC_MS * 1000 * `EPH_CLK_MHZ)
`define EPH_LOCK_MS        10
`define EPH_LOCK_CYC       (`EPH_LOCK_MS * 1000 * `EPH_CLK_MHZ)

`define EPH_CNT_W          12
`define EPH_LONG_W         20

`endif

// *** eph_timer.v ***
// Long one-shot down-counter for lockout and program-cycle timeouts
`timescale 1ns/1ps
module eph_timer
#(
    parameter [19:0] LOAD         = 20'h00001,
    parameter        RUN_AT_RESET = 0
)
(
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        clk_en,
    input  wire        start,
    output reg         done_ff
);
    localparam [0:0] RUN_INIT = (RUN_AT_RESET != 0) ? 1'b1 : 1'b0;

    reg  [19:0] cnt_ff;
    reg         run_ff;

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cnt_ff  <= LOAD;
            run_ff  <= RUN_INIT;
            done_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                cnt_ff  <= LOAD;
                run_ff  <= 1'b1;
                done_ff <= 1'b0;
            end
            else if (run_ff)
            begin
                if (cnt_ff <= 20'h00001)
                begin
                    run_ff  <= 1'b0;
                    done_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff - 20'h00001;
            end
        end
    end
endmodule // eph_timer

// *** eph_mem_model.sv ***
// Behavioural model of the parallel nonvolatile memory on the host's far side
`timescale 1ns/1ps
module eph_mem_model
#(
    parameter integer BLC_NS  = 90000,
    parameter integer PROG_NS = 2000,
    parameter integer LOCK_NS = 1000
)
(
    input  wire        ce_n,
    input  wire        we_n,
    input  wire        oe_n,
    input  wire        hang,
    input  wire [12:0] addr,
    input  wire [7:0]  din,
    output wire [7:0]  dout
);
    reg  [7:0]  mem [0:8191];
    reg  [7:0]  pbuf [0:31];
    reg  [31:0] pvld = 32'h0;
    reg  [12:0] a_lat = 13'h0;
    reg  [7:0]  pg = 8'h0;
    reg  [7:0]  last_d = 8'h0;
    reg  [7:0]  held = 8'h0;
    reg         prog = 1'b0;
    reg         tog = 1'b0;
    realtime    t_rise = 0;
    realtime    t_fall = 0;
    integer     i;
    // Busy status read at every address, simplest form
    wire [7:0]  rd = prog ? {~last_d[7], tog, 6'h15} : mem[addr];
    wire        rd_on = !ce_n && !oe_n && we_n;
    // Released bus shows the inverse so a stale value never passes
    assign dout = rd_on ? rd : ~held;
    initial
        for (i = 0; i < 8192; i = i + 1)
            mem[i] = 8'hff;
    always @(rd or rd_on)
        if (rd_on)
            held = rd;
    always @(negedge oe_n)
        if (prog)
            tog = ~tog;
    // Write-strobe controlled only; the host never uses select as the edge
    always @(negedge we_n)
        if (!ce_n && oe_n)
        begin
            t_fall = $realtime;
            a_lat = addr;
        end
    always @(posedge we_n)
        if (!ce_n && oe_n && !prog && $realtime >= LOCK_NS && $realtime - t_fall >= 20)
        begin
            pbuf[a_lat[4:0]] = din;
            pvld[a_lat[4:0]] = 1'b1;
            pg = a_lat[12:5];
            last_d = din;
            t_rise = $realtime;
        end
    // Timer runs below the host's load window so programming starts before its first poll
    initial forever
    begin
        #100;
        if (pvld != 32'h0 && we_n && $realtime - t_rise >= BLC_NS)
        begin
            prog = 1'b1;
            #(PROG_NS);
            wait (!hang);
            for (i = 0; i < 32; i = i + 1)
                if (pvld[i])
                begin
                    mem[{pg, i[4:0]}] = 8'hff;
                    mem[{pg, i[4:0]}] = pbuf[i];
                end
            pvld = 32'h0;
            prog = 1'b0;
        end
    end
endmodule // eph_mem_model

// *** eph_host_properties.sv ***
// Concurrent checks on the memory-side pins of the host controller
`timescale 1ns/1ps
module eph_host_props
(
    input wire        clk_sys,
    input wire        reset,
    input wire        rd_valid_ff,
    input wire [7:0]  rd_data_ff,
    input wire        mem_ce_n_ff,
    input wire        mem_we_n_ff,
    input wire        mem_oe_n_ff,
    input wire [12:0] addr_lines_ff,
    input wire [7:0]  data_lines_out_ff,
    input wire        data_lines_oe_n_ff,
    input wire [7:0]  data_lines_in
);
    reg [12:0] since_ff;
    reg        polled_ff;
    reg        we_q_ff;
    wire       we_rise = mem_we_n_ff && !we_q_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Cycles since the last strobe rise, saturating
    always @(posedge clk_sys or posedge reset)
        if (reset)
        begin
            since_ff  <= 13'h1fff;
            polled_ff <= 1'b1;
            we_q_ff   <= 1'b1;
        end
        else
        begin
            since_ff  <= we_rise ? 13'h0001 : since_ff + {12'h000, since_ff != 13'h1fff};
            polled_ff <= we_rise ? 1'b0 : polled_ff | !mem_oe_n_ff;
            we_q_ff   <= mem_we_n_ff;
        end
    write_ctl_a: assert property (!mem_we_n_ff |-> !mem_ce_n_ff && mem_oe_n_ff && !data_lines_oe_n_ff)
        else $error("strobe low without select or with output enable");
    read_free_a: assert property (!mem_oe_n_ff |-> data_lines_oe_n_ff && mem_we_n_ff)
        else $error("host drives data while memory output enabled");
    pulse_wide_a: assert property ($fell(mem_we_n_ff) |-> !mem_we_n_ff [*6])
        else $error("write strobe shorter than six cycles");
    strobe_stable_a: assert property ($fell(mem_we_n_ff) |-> ($stable(addr_lines_ff) && $stable(data_lines_out_ff)) [*6])
        else $error("address or data moved around strobe fall");
    hold_after_a: assert property ($rose(mem_we_n_ff) |-> ($stable(addr_lines_ff) && !mem_ce_n_ff && !data_lines_oe_n_ff) [*4])
        else $error("address, select or data released too early");
    load_window_a: assert property ($fell(mem_we_n_ff) && !polled_ff |-> since_ff < 13'd2100)
        else $error("next byte load late in window");
    prog_wait_a: assert property ($fell(mem_oe_n_ff) && !polled_ff |-> since_ff >= 13'd3990)
        else $error("polling began before load window ran out");
    read_data_a: assert property (rd_valid_ff |-> rd_data_ff == $past(data_lines_in) && $rose(mem_oe_n_ff))
        else $error("read data not taken from last access cycle");
    rd_cov: cover property (rd_valid_ff);
    page_cov: cover property ($fell(mem_we_n_ff) && !polled_ff);
    poll_cov: cover property ($fell(mem_oe_n_ff) && !polled_ff);
endmodule // eph_host_props
bind eph_host eph_host_props chk_u (.clk_sys(clk_sys), .reset(reset), .rd_valid_ff(rd_valid_ff),
    .rd_data_ff(rd_data_ff), .mem_ce_n_ff(mem_ce_n_ff), .mem_we_n_ff(mem_we_n_ff), .mem_oe_n_ff(mem_oe_n_ff),
    .addr_lines_ff(addr_lines_ff), .data_lines_out_ff(data_lines_out_ff),
    .data_lines_oe_n_ff(data_lines_oe_n_ff), .data_lines_in(data_lines_in));

// *** eph_host_test.sv ***
// Self-checking bench for the parallel memory host controller
`timescale 1ns/1ps
`include "eph_consts.vh"
module eph_host_test;
    reg                    clk_sys = 1'b0;
    reg                    reset = 1'b1;
    reg                    cmd_valid = 1'b0;
    reg                    cmd_write = 1'b0;
    reg                    hang = 1'b0;
    reg                    clk_en = 1'b1;
    reg  [`EPH_ADDR_W-1:0] cmd_addr = 13'h0000;
    reg  [`EPH_DATA_W-1:0] cmd_data = 8'h00;
    wire                   ack, rd_valid, wr_done, wr_to, busy, ce_n, we_n, oe_n, d_oe_n;
    wire [`EPH_ADDR_W-1:0] addr;
    wire [`EPH_DATA_W-1:0] rd_data, d_out, mdl_q;
    wire [`EPH_DATA_W-1:0] bus = d_oe_n ? mdl_q : d_out;
    integer                err_total = 0, n_tests = 0, cyc = 0, waited = 0, i;
    eph_host #(.TWC_CYC(20'h0012c), .LOCK_CYC(20'h00032)) dut_u (.clk_sys(clk_sys), .reset(reset),
        .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ack_ff(ack), .rd_data_ff(rd_data), .rd_valid_ff(rd_valid), .wr_done_ff(wr_done),
        .wr_timeout_ff(wr_to), .busy_ff(busy), .mem_ce_n_ff(ce_n), .mem_we_n_ff(we_n), .mem_oe_n_ff(oe_n),
        .addr_lines_ff(addr), .data_lines_out_ff(d_out), .data_lines_oe_n_ff(d_oe_n), .data_lines_in(bus));
    eph_mem_model mem_u (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .hang(hang), .addr(addr), .din(bus),
        .dout(mdl_q));
    task conclude;
    begin
        $display("mismatches %0d comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    task chk1(input got, input exp);
    begin
        chk8({7'h00, got}, {7'h00, exp});
    end
    endtask
    // Request held until the acknowledge is seen, then one idle edge
    task issue(input w, input [12:0] a, input [7:0] d);
    begin
        waited = 0;
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1 && waited < 8000)
        begin
            @(posedge clk_sys);
            waited = waited + 1;
        end
        chk1(ack, 1'b1);
        cmd_valid <= 1'b0;
        @(posedge clk_sys);
    end
    endtask
    task rd_chk(input [12:0] a, input [7:0] exp);
        integer n;
    begin
        n = 0;
        issue(1'b0, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk1(rd_valid, 1'b1);
        chk8(rd_data, exp);
    end
    endtask
    task wr_wait(input to_exp);
        integer n;
    begin
        n = 0;
        while (wr_done !== 1'b1 && n < 12000)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk1(wr_done, 1'b1);
        chk1(wr_to, to_exp);
        @(posedge clk_sys);
    end
    endtask
    task t_byte;
    begin
        issue(1'b1, 13'h0143, 8'ha5);
        wr_wait(1'b0);
        rd_chk(13'h0143, 8'ha5);
    end
    endtask
    // Enable held low mid-read: access stretches by exactly the frozen cycles
    task t_freeze;
    begin
        issue(1'b0, 13'h0143, 8'h00);
        clk_en <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk1(rd_valid | oe_n, 1'b0);
        clk_en <= 1'b1;
        repeat (9) @(posedge clk_sys);
        chk1(rd_valid, 1'b1);
        chk8(rd_data, 8'ha5);
    end
    endtask
    task t_page;
    begin
        issue(1'b1, {8'h0a, 5'h09}, 8'h3c);
        wr_wait(1'b0);
        issue(1'b1, {8'h0a, 5'h1f}, 8'h11);
        issue(1'b1, {8'h0a, 5'h02}, 8'h22);
        issue(1'b1, {8'h0a, 5'h11}, 8'h33);
        wr_wait(1'b0);
        rd_chk({8'h0a, 5'h09}, 8'h3c);
        rd_chk({8'h0a, 5'h1f}, 8'h11);
        rd_chk({8'h0a, 5'h02}, 8'h22);
        rd_chk({8'h0a, 5'h11}, 8'h33);
    end
    endtask
    task t_full;
    begin
        for (i = 0; i < 32; i = i + 1)
            issue(1'b1, {8'h5c, i[4:0]}, i[7:0] ^ 8'ha6);
        wr_wait(1'b0);
        for (i = 0; i < 32; i = i + 1)
            rd_chk({8'h5c, i[4:0]}, i[7:0] ^ 8'ha6);
    end
    endtask
    // Memory held busy: toggle never settles, host must give up
    task t_hang;
    begin
        hang <= 1'b1;
        issue(1'b1, 13'h1fe0, 8'h77);
        wr_wait(1'b1);
        hang <= 1'b0;
        repeat (4) @(posedge clk_sys);
        issue(1'b1, 13'h1fe1, 8'h78);
        wr_wait(1'b0);
        rd_chk(13'h1fe0, 8'h77);
        rd_chk(13'h1fe1, 8'h78);
    end
    endtask
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 60000)
        begin
            err_total = err_total + 1;
            $display("[ERR] %0t run too long", $time);
            conclude;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk1(busy, 1'b1);
        rd_chk(13'h0000, 8'hff);
        chk1(waited >= 40, 1'b1);
        chk1(busy, 1'b0);
        t_byte;
        t_freeze;
        t_page;
        t_full;
        t_hang;
        conclude;
    end
endmodule // eph_host_test
